// ### alu_bit_defs.svh
// Constants for the add/and/bit-clear/bit-test execute block
`ifndef ALU_BIT_DEFS_SVH
`define ALU_BIT_DEFS_SVH

// ****************************************
// Instruction fields
// ****************************************
`define INSTR_W 14
`define OPC6_ADD 6'h07
`define OPC6_AND 6'h05
`define OPC4_BCLR 4'h4
`define OPC4_BTST 4'h6
`define DEST_BIT 7
`define REG_FIELD_W 7
`define BIT_FIELD_W 3
`define REG_COUNT 128
`define DATA_W 8

// ****************************************
// Register map, byte addresses
// ****************************************
`define AXI_ADDR_W 12
`define ADDR_CTRL 12'h000
`define ADDR_ACC 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_RETIRED 12'h00C
`define ADDR_FILE_TAG 3'h1
`define CTRL_EN_RST 1'b1
`define COUNT_W 16
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### alu_bit_pkg.sv
// Types shared by the execute block and its arithmetic unit
package alu_bit_pkg;
`include "alu_bit_defs.svh"

  typedef enum logic [4:0] {
    OP_NOP  = 5'h01,
    OP_ADD  = 5'h02,
    OP_AND  = 5'h04,
    OP_BCLR = 5'h08,
    OP_BTST = 5'h10
  } op_t;

  typedef struct packed {
    logic [`DATA_W-1:0] data;
    logic carry;
    logic half;
    logic zero;
    logic skip;
  } alu_result_t;

  typedef struct packed {
    logic [`REG_COUNT-1:0][`DATA_W-1:0] regs;
    logic [`DATA_W-1:0] acc;
    logic carry;
    logic half;
    logic zero;
    logic skip;
    logic enable;
    logic retire;
    logic retire_nop;
    logic [`COUNT_W-1:0] count;
    logic aw_hold;
    logic [`AXI_ADDR_W-1:0] awaddr;
    logic w_hold;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;
endpackage

// ### alu_bit_core.sv
// Combinational arithmetic and bit unit
`timescale 1ns/1ps
module alu_bit_core (
  input alu_bit_pkg::op_t op,
  input wire logic [7:0] acc,
  input wire logic [7:0] operand,
  input wire logic [2:0] bit_sel,
  output alu_bit_pkg::alu_result_t res
);
  import alu_bit_pkg::*;

  logic [8:0] sum;
  logic [4:0] low_sum;

  always_comb begin
    sum = {1'b0, acc} + {1'b0, operand};
    low_sum = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
    res = '0;
    unique case (op)
      OP_ADD: begin
        res.data = sum[7:0];
        res.carry = sum[8];
        res.half = low_sum[4];
      end
      OP_AND: res.data = acc & operand;
      OP_BCLR: begin
        res.data = operand;
        res.data[bit_sel] = 1'b0;
      end
      OP_BTST: begin
        res.data = operand;
        res.skip = ~operand[bit_sel];
      end
      OP_NOP: res.data = operand;
    endcase
    res.zero = (res.data == 8'h00);
  end
endmodule

// ### alu_bit_instruction_decode.sv
// Execute stage for add, AND, bit clear and bit test with skip, plus AXI4-Lite slave
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "alu_bit_defs.svh"
module alu_bit_instruction_decode (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  output logic instr_ready,
  output logic retire_valid,
  output logic retire_nop,
  output logic skip_pending,
  output logic [7:0] acc_value,
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  import alu_bit_pkg::*;

  state_t s_reg;
  state_t s_next;
  op_t op;
  alu_result_t res;
  logic [6:0] cur_f;
  logic [2:0] cur_b;
  logic dest_reg;
  logic [7:0] operand;
  logic wr_go;
  logic fire;
  logic exec;
  logic [8:0] sum9;
  logic [4:0] low5;

  // ****************************************
  // Decode
  // ****************************************
  assign cur_f = instr_word[6:0];
  assign cur_b = instr_word[9:7];
  assign dest_reg = instr_word[`DEST_BIT];
  assign operand = s_reg.regs[cur_f];

  always_comb begin
    if (instr_word[13:8] == `OPC6_ADD) begin
      op = OP_ADD;
    end else if (instr_word[13:8] == `OPC6_AND) begin
      op = OP_AND;
    end else if (instr_word[13:10] == `OPC4_BCLR) begin
      op = OP_BCLR;
    end else if (instr_word[13:10] == `OPC4_BTST) begin
      op = OP_BTST;
    end else begin
      op = OP_NOP;
    end
  end

  alu_bit_core u_core (
    .op(op),
    .acc(s_reg.acc),
    .operand(operand),
    .bit_sel(cur_b),
    .res(res)
  );

  // ****************************************
  // Handshakes
  // ****************************************
  // Bus write wins the register file; the core stalls that one cycle
  assign wr_go = s_reg.aw_hold & s_reg.w_hold & ~s_reg.bvalid;
  assign instr_ready = s_reg.enable & ~wr_go;
  assign fire = instr_valid & instr_ready;
  assign exec = fire & ~s_reg.skip;
  assign awready = ~s_reg.aw_hold;
  assign wready = ~s_reg.w_hold;
  assign arready = ~s_reg.rvalid;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign retire_valid = s_reg.retire;
  assign retire_nop = s_reg.retire_nop;
  assign skip_pending = s_reg.skip;
  assign acc_value = s_reg.acc;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_next = s_reg;
    s_next.retire = 1'b0;
    s_next.retire_nop = 1'b0;
    if (awvalid && !s_reg.aw_hold) begin
      s_next.aw_hold = 1'b1;
      s_next.awaddr = awaddr;
    end
    if (wvalid && !s_reg.w_hold) begin
      s_next.w_hold = 1'b1;
      s_next.wdata = wdata;
      s_next.wstrb = wstrb;
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end
    if (wr_go) begin
      s_next.aw_hold = 1'b0;
      s_next.w_hold = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = `RESP_OKAY;
      if (s_reg.awaddr[11:9] == `ADDR_FILE_TAG) begin
        if (s_reg.wstrb[0]) begin
          s_next.regs[s_reg.awaddr[8:2]] = s_reg.wdata[7:0];
        end
      end else if (s_reg.awaddr == `ADDR_CTRL) begin
        if (s_reg.wstrb[0]) begin
          s_next.enable = s_reg.wdata[0];
        end
      end else if (s_reg.awaddr == `ADDR_ACC) begin
        if (s_reg.wstrb[0]) begin
          s_next.acc = s_reg.wdata[7:0];
        end
      end else if (s_reg.awaddr != `ADDR_STATUS && s_reg.awaddr != `ADDR_RETIRED) begin
        s_next.bresp = `RESP_SLVERR;
      end
    end
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
    end else if (arvalid && !s_reg.rvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = `RESP_OKAY;
      s_next.rdata = 32'h0000_0000;
      if (araddr[11:9] == `ADDR_FILE_TAG) begin
        s_next.rdata[7:0] = s_reg.regs[araddr[8:2]];
      end else if (araddr == `ADDR_CTRL) begin
        s_next.rdata[0] = s_reg.enable;
      end else if (araddr == `ADDR_ACC) begin
        s_next.rdata[7:0] = s_reg.acc;
      end else if (araddr == `ADDR_STATUS) begin
        s_next.rdata[3:0] = {s_reg.skip, s_reg.zero, s_reg.half, s_reg.carry};
      end else if (araddr == `ADDR_RETIRED) begin
        s_next.rdata[15:0] = s_reg.count;
      end else begin
        s_next.rresp = `RESP_SLVERR;
      end
    end
    if (fire) begin
      s_next.retire = 1'b1;
      s_next.count = s_reg.count + 16'h0001;
      if (s_reg.skip) begin
        // Prefetched word is dropped, slot retires as a no-operation
        s_next.skip = 1'b0;
        s_next.retire_nop = 1'b1;
      end else begin
        unique case (op)
          OP_ADD, OP_AND: begin
            if (dest_reg) begin
              s_next.regs[cur_f] = res.data;
            end else begin
              s_next.acc = res.data;
            end
            s_next.zero = res.zero;
            if (op == OP_ADD) begin
              s_next.carry = res.carry;
              s_next.half = res.half;
            end
          end
          OP_BCLR: s_next.regs[cur_f] = res.data;
          OP_BTST: s_next.skip = res.skip;
          OP_NOP: s_next.skip = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.enable <= `CTRL_EN_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  assign sum9 = {1'b0, s_reg.acc} + {1'b0, operand};
  assign low5 = {1'b0, s_reg.acc[3:0]} + {1'b0, operand[3:0]};

  property p_add_result;
    exec && op == OP_ADD && !dest_reg |=> s_reg.acc == $past(sum9[7:0]);
  endproperty
  a_add_result: assert property (p_add_result) else $error("add result wrong");

  property p_dest_reg;
    exec && (op == OP_ADD || op == OP_AND) && dest_reg
      |=> s_reg.acc == $past(s_reg.acc) && s_reg.regs[$past(cur_f)] == $past(res.data);
  endproperty
  a_dest_reg: assert property (p_dest_reg) else $error("destination select wrong");

  property p_and_flags;
    exec && op == OP_AND
      |=> s_reg.carry == $past(s_reg.carry) && s_reg.half == $past(s_reg.half)
        && s_reg.zero == ($past(s_reg.acc & operand) == 8'h00);
  endproperty
  a_and_flags: assert property (p_and_flags) else $error("and flags wrong");

  property p_bclr;
    exec && op == OP_BCLR
      |=> s_reg.regs[$past(cur_f)][$past(cur_b)] == 1'b0 && s_reg.zero == $past(s_reg.zero);
  endproperty
  a_bclr: assert property (p_bclr) else $error("bit clear wrong");

  property p_operand_fetch;
    exec && op == OP_BCLR
      |=> s_reg.regs[$past(cur_f)] == ($past(operand) & ~(8'h01 << $past(cur_b)));
  endproperty
  a_operand_fetch: assert property (p_operand_fetch) else $error("operand address wrong");

  property p_btst_skip;
    exec && op == OP_BTST
      |=> s_reg.skip == !$past(operand[cur_b]) && s_reg.carry == $past(s_reg.carry);
  endproperty
  a_btst_skip: assert property (p_btst_skip) else $error("bit test skip wrong");

  property p_skip_nop;
    fire && s_reg.skip |=> retire_nop && !s_reg.skip && s_reg.acc == $past(s_reg.acc);
  endproperty
  a_skip_nop: assert property (p_skip_nop) else $error("skip slot not a no-op");

  property p_add_flags;
    exec && op == OP_ADD
      |=> s_reg.carry == $past(sum9[8]) && s_reg.half == $past(low5[4])
        && s_reg.zero == ($past(sum9[7:0]) == 8'h00);
  endproperty
  a_add_flags: assert property (p_add_flags) else $error("add flags wrong");

  c_skip_taken: cover property (exec && op == OP_BTST && res.skip ##1 fire);
  c_add_carry: cover property (exec && op == OP_ADD && sum9[8]);
  c_bus_stall: cover property (instr_valid && wr_go);
endmodule

// ### fetch_model.sv
// Instruction fetch model that offers queued words to the execute block
`timescale 1ns/1ps
module fetch_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic instr_ready,
  output logic instr_valid,
  output logic [13:0] instr_word
);
  // ****************************************
  // Word queue and handshake
  // ****************************************
  logic [13:0] words[$];
  int idx = 0;

  initial begin
    instr_valid = 1'b0;
    instr_word = 14'h0000;
  end

  // Idle word flips each cycle so a stale value never passes for a real one
  always @(posedge aclk) begin
    if (instr_valid && instr_ready)
      idx = idx + 1;
    if (aresetn && idx < words.size()) begin
      instr_valid <= 1'b1;
      instr_word <= words[idx];
    end else begin
      instr_valid <= 1'b0;
      instr_word <= ~instr_word;
    end
  end
endmodule

// ### tb.sv
// Self-checking testbench for the execute block and its register bus
`timescale 1ns/1ps
module tb;
  // ****************************************
  // Signals
  // ****************************************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic instr_valid, instr_ready, retire_valid, retire_nop, skip_pending;
  logic awready, wready, bvalid, arready, rvalid;
  logic [13:0] instr_word;
  logic [7:0] acc_value;
  logic [1:0] bresp, rresp, bs, rs;
  logic [31:0] rdata, rd;
  int num_errors = 0, compares = 0, nret = 0, nnop = 0;

  always #2.5 aclk = ~aclk;

  alu_bit_instruction_decode uut (.aclk, .aresetn, .instr_valid, .instr_word, .instr_ready,
    .retire_valid, .retire_nop, .skip_pending, .acc_value, .awvalid, .awready, .awaddr,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp);

  fetch_model fm (.aclk, .aresetn, .instr_ready, .instr_valid, .instr_word);

  always @(posedge aclk) begin
    if (retire_valid === 1'b1) begin
      nret++;
      if (retire_nop === 1'b1)
        nnop++;
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge aclk);
    {aw, w, b} = 3'h0;
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hf, 3'h7};
    while (!b) begin
      @(posedge aclk);
      if (awvalid && awready)
        aw = 1'b1;
      if (aw)
        awvalid <= 1'b0;
      if (wvalid && wready)
        w = 1'b1;
      if (w)
        wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        b = 1'b1;
        bs = bresp;
        bready <= 1'b0;
      end
    end
  endtask

  task rdr(input logic [11:0] a);
    logic r;
    @(posedge aclk);
    r = 1'b0;
    {araddr, arvalid, rready} <= {a, 2'h3};
    while (!r) begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        r = 1'b1;
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
      end
    end
  endtask

  task rc(input logic [11:0] a, input logic [31:0] e);
    rdr(a);
    chk(rd, e);
  endtask

  function logic [13:0] wf(input logic [5:0] op, input logic d, input logic [6:0] f);
    return {op, d, f};
  endfunction

  task ex(input logic [13:0] w);
    fm.words.push_back(w);
  endtask

  // Bounded only by the watchdog
  task drain;
    while (fm.idx < fm.words.size())
      @(posedge aclk);
    repeat (2) @(posedge aclk);
  endtask

  task close_out;
    $display("Errors %0d, compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    #50000;
    num_errors++;
    close_out;
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rc(12'h000, 32'h0000_0001);
    rc(12'h004, 32'h0000_0000);
    rc(12'h008, 32'h0000_0000);
    wr(12'h004, 32'h0000_0088);
    wr(12'h214, 32'h0000_0078);
    ex(wf(6'h07, 1'b0, 7'h05));
    drain;
    rc(12'h004, 32'h0000_0000);
    #1 chk(acc_value, 32'h0000_0000);
    rc(12'h008, 32'h0000_0007);
    wr(12'h004, 32'h0000_00ff);
    ex(wf(6'h05, 1'b1, 7'h05));
    drain;
    rc(12'h214, 32'h0000_0078);
    rc(12'h008, 32'h0000_0003);
    ex(wf(6'h07, 1'b1, 7'h05));
    drain;
    rc(12'h214, 32'h0000_0077);
    rc(12'h004, 32'h0000_00ff);
    rc(12'h008, 32'h0000_0003);
    // Back to back issue, skip discards the add right behind it
    wr(12'h004, 32'h0000_0017);
    wr(12'h3fc, 32'h0000_00c2);
    wr(12'h20c, 32'h0000_00c7);
    ex(wf(6'h05, 1'b1, 7'h7f));
    ex({4'h4, 3'h7, 7'h03});
    ex({4'h6, 3'h7, 7'h03});
    ex(wf(6'h07, 1'b0, 7'h7f));
    ex({4'h6, 3'h6, 7'h03});
    ex(wf(6'h07, 1'b0, 7'h7f));
    drain;
    rc(12'h3fc, 32'h0000_0002);
    rc(12'h20c, 32'h0000_0047);
    rc(12'h004, 32'h0000_0019);
    rc(12'h008, 32'h0000_0000);
    chk(nret, 32'h0000_0009);
    chk(nnop, 32'h0000_0001);
    rc(12'h00c, 32'h0000_0009);
    // Skip left pending, then a discarded add and an undecoded word
    ex({4'h6, 3'h3, 7'h05});
    drain;
    #1 chk(skip_pending, 1'b1);
    ex(wf(6'h07, 1'b0, 7'h05));
    ex(14'h0000);
    drain;
    #1 chk(skip_pending, 1'b0);
    chk(acc_value, 32'h0000_0019);
    rc(12'h008, 32'h0000_0000);
    wr(12'h100, 32'h0000_0000);
    chk(bs, 2'h2);
    rc(12'h100, 32'h0000_0000);
    chk(rs, 2'h2);
    wr(12'h000, 32'h0000_0000);
    #1 chk(instr_ready, 1'b0);
    wr(12'h000, 32'h0000_0001);
    #1 chk(instr_ready, 1'b1);
    close_out;
  end
endmodule
